/* eng_stop_defines.vh */
`ifndef ENG_STOP_DEFINES_VH
`define ENG_STOP_DEFINES_VH

// Register byte offsets
`define REG_COOL_TIME   8'h00
`define REG_FUEL_DELAY  8'h04
`define REG_STOP_PULSE  8'h08
`define REG_STOP_MAX    8'h0c
`define REG_MASK_TIME   8'h10
`define REG_PREDELIVERY 8'h14
`define REG_SRC_SEL     8'h18
`define REG_COOL_THR    8'h1c
`define REG_EVT_EN      8'h20
`define REG_CMD         8'h24
`define REG_STATUS      8'h28
`define REG_LAST_EVT    8'h2c

// Timer slots, also the word index of their span register
`define TMR_COOL   0
`define TMR_FUEL   1
`define TMR_PULSE  2
`define TMR_MAX    3
`define TMR_MASK   4
`define TMR_PRED   5
`define TMR_COUNT  6
`define TMR_WORDS  6'h06

// Command register bits
`define CMD_STD_STOP  0
`define CMD_EMG_STOP  1
`define CMD_MAN_STOP  2
`define CMD_CLR_ALARM 3

// Event enable bits
`define EVTEN_STATE 4
`define EVTEN_REQ   7

// Event codes
`define EVT_STATE_BASE 16'h0410
`define EVT_REQ_BASE   16'h041a
`define REQ_COUNT      14

// Services supply source that never cuts cooling
`define SRC_GEN 2'h0

// Status register layout
`define STAT_ALARM     9
`define STAT_STATE_LSB 12

// Reset values
`define RST_SPAN   16'h0000
`define RST_SRC    2'h0
`define RST_THR    16'h0000
`define RST_EVT_EN 16'h0000

`endif

/* sec_timer.v */
`timescale 1ns/10ps
`default_nettype none

module sec_timer #(
   parameter W = 16
) (
   // Clock and control
   input  wire         mclk,
   input  wire         rstn,
   input  wire         ce,
   input  wire         tick,
   // Load and abort
   input  wire         start,
   input  wire         clr,
   input  wire [W-1:0] span,
   // State
   output reg          busy,
   output reg          fin
);

   reg [W-1:0] count;

   // Counts whole seconds; a zero span finishes at once
   always @(posedge mclk) begin
      if (!rstn) begin
         busy  <= 1'b0;
         fin   <= 1'b0;
         count <= {W{1'b0}};
      end else if (ce) begin
         if (clr) begin
            busy <= 1'b0;
            fin  <= 1'b0;
         end else if (start) begin
            count <= span;
            busy  <= |span;
            fin   <= ~|span;
         end else if (busy && tick) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
            if (count == {{(W-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               fin  <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* engine_stop_sequencer.v */
`timescale 1ns/10ps
`default_nettype none

`include "eng_stop_defines.vh"

module engine_stop_sequencer #(
   parameter TW = 16
) (
   // Clock, reset, enable
   input  wire        mclk,
   input  wire        rstn,
   input  wire        ce,
   input  wire        secTick,
   // Avalon-MM slave
   input  wire [7:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Requests
   input  wire        startReq,
   input  wire        runReq,
   input  wire        stdStopReq,
   input  wire        emgStopReq,
   input  wire        manStopReq,
   input  wire [13:0] reqChange,
   // Engine and breaker state
   input  wire        engineStarted,
   input  wire        engineTurning,
   input  wire        lowSpeedReq,
   input  wire        autoMode,
   input  wire        generatorBreakerClosed,
   input  wire        generatorBreakerOpenCmd,
   input  wire        dischargeDone,
   input  wire [15:0] coolantTemp,
   input  wire [3:0]  srcVoltOk,
   // Actuators
   output reg         engineElectronicsEnable,
   output reg         fuelOut,
   output reg         stopOut,
   output reg         oilProtMask,
   // Signals and alarm
   output reg         engineRunningOutput,
   output reg         readyToSupplyOutput,
   output reg  [8:0]  statusFlags,
   output reg         engineNotStoppedAlarm,
   // Event log
   output reg         eventValid,
   output reg  [15:0] eventCode
);

   localparam ST_IDLE     = 3'h0;
   localparam ST_STARTING = 3'h1;
   localparam ST_RUNNING  = 3'h2;
   localparam ST_COOLING  = 3'h3;
   localparam ST_STOPPING = 3'h4;
   localparam ST_LOWSPEED = 3'h5;

   reg  [2:0]     state;
   reg  [2:0]     next_state;
   reg  [TW-1:0]  span [0:`TMR_COUNT-1];
   reg  [1:0]     srcSel;
   reg  [15:0]    coolThr;
   reg  [15:0]    evtEn;
   reg  [15:0]    lastEvt;
   reg  [13:0]    reqPend;
   reg            stdPend;
   reg            breakerUsed;
   reg            pulseArmed;
   reg            busAck;
   wire [`TMR_COUNT-1:0] tStart;
   wire [`TMR_COUNT-1:0] tClr;
   wire [`TMR_COUNT-1:0] tBusy;
   wire [`TMR_COUNT-1:0] tFin;

   // Index of the lowest pending request
   function [3:0] firstSet;
      input [13:0] v;
      integer i;
      begin
         firstSet = 4'h0;
         for (i = `REQ_COUNT - 1; i >= 0; i = i - 1) begin
            if (v[i]) begin
               firstSet = i[3:0];
            end
         end
      end
   endfunction

   // Engine is in one of the phases that keeps fuel on
   function runPhase;
      input [2:0] s;
      begin
         runPhase = (s == ST_STARTING) || (s == ST_RUNNING) ||
                    (s == ST_LOWSPEED) || (s == ST_COOLING);
      end
   endfunction

   // Bus strobes: one wait cycle, then the access completes
   wire wrEn  = write & busAck;
   wire cmdWr = wrEn & (address == `REG_CMD);
   wire stdStop = stdStopReq | (cmdWr & writedata[`CMD_STD_STOP]);
   wire emgStop = emgStopReq | (cmdWr & writedata[`CMD_EMG_STOP]);
   wire manStop = manStopReq | (cmdWr & writedata[`CMD_MAN_STOP]);
   wire alarmClr = cmdWr & writedata[`CMD_CLR_ALARM];

   assign waitrequest = ~(busAck & ce);

   // Stop conditions
   wire breakerOff = ~generatorBreakerClosed | generatorBreakerOpenCmd;
   wire stdGo = (stdPend | stdStop) & breakerOff & dischargeDone;
   wire thrSet = |coolThr;
   wire hot = thrSet & (coolantTemp > coolThr);
   wire needCool = breakerUsed | hot;
   wire coldEnough = thrSet & (coolantTemp < coolThr);
   wire srcLost = (srcSel != `SRC_GEN) & ~srcVoltOk[srcSel];
   wire coolEnd = tFin[`TMR_COOL] | coldEnough | srcLost;

   // Next engine phase
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (emgStop) begin
               next_state = ST_STOPPING;
            end else if (startReq) begin
               next_state = ST_STARTING;
            end
         end
         ST_STARTING: begin
            if (emgStop || stdGo) begin
               next_state = ST_STOPPING;
            end else if (engineStarted) begin
               next_state = ST_RUNNING;
            end
         end
         ST_RUNNING, ST_LOWSPEED: begin
            if (emgStop) begin
               next_state = ST_STOPPING;
            end else if (stdGo) begin
               next_state = needCool ? ST_COOLING : ST_STOPPING;
            end else if (lowSpeedReq) begin
               next_state = ST_LOWSPEED;
            end else begin
               next_state = ST_RUNNING;
            end
         end
         ST_COOLING: begin
            if (emgStop || manStop || coolEnd) begin
               next_state = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            if (tFin[`TMR_MAX]) begin
               next_state = ST_IDLE;
            end else if (runReq && !engineTurning) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   wire change = next_state != state;
   wire toStop = change & (next_state == ST_STOPPING);
   wire toRun = change & (state == ST_STARTING) & (next_state == ST_RUNNING);
   wire toIdle = change & (next_state == ST_IDLE);
   wire leaveStop = change & (state == ST_STOPPING);

   // Timer loads and aborts
   assign tStart[`TMR_COOL]  = change & (next_state == ST_COOLING);
   assign tStart[`TMR_FUEL]  = toStop;
   assign tStart[`TMR_PULSE] = (state == ST_STOPPING) & tFin[`TMR_FUEL] &
                               ~pulseArmed;
   assign tStart[`TMR_MAX]   = toStop;
   assign tStart[`TMR_MASK]  = toRun;
   assign tStart[`TMR_PRED]  = toRun;
   assign tClr[`TMR_COOL]    = 1'b0;
   assign tClr[`TMR_FUEL]    = 1'b0;
   assign tClr[`TMR_PULSE]   = toStop | leaveStop;
   assign tClr[`TMR_MAX]     = 1'b0;
   assign tClr[`TMR_MASK]    = toIdle;
   assign tClr[`TMR_PRED]    = toIdle;

   // One seconds timer per delay
   genvar g;
   generate
      for (g = 0; g < `TMR_COUNT; g = g + 1) begin : tmr
         sec_timer #(
            .W (TW)
         ) u_timer (
            .mclk  (mclk),
            .rstn  (rstn),
            .ce    (ce),
            .tick  (secTick),
            .start (tStart[g]),
            .clr   (tClr[g]),
            .span  (span[g]),
            .busy  (tBusy[g]),
            .fin   (tFin[g])
         );
      end
   endgenerate

   // Output intent for the coming cycle
   wire fuelNow = runPhase(state) |
                  ((state == ST_STOPPING) & tBusy[`TMR_FUEL]);
   wire stopNow = (state == ST_STOPPING) & tBusy[`TMR_PULSE] &
                  ~fuelNow;
   wire enableNow = runPhase(state);

   // Phase, pending stop, breaker memory and actuators
   always @(posedge mclk) begin
      if (!rstn) begin
         state                   <= ST_IDLE;
         stdPend                 <= 1'b0;
         breakerUsed             <= 1'b0;
         pulseArmed              <= 1'b0;
         engineElectronicsEnable <= 1'b0;
         fuelOut                 <= 1'b0;
         stopOut                 <= 1'b0;
         oilProtMask             <= 1'b0;
         engineNotStoppedAlarm   <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         stdPend <= (stdPend | stdStop) & ~(toStop | tStart[`TMR_COOL]) &
                    ~(state == ST_IDLE);
         if (toIdle) begin
            breakerUsed <= 1'b0;
         end else if (generatorBreakerClosed && autoMode &&
                      runPhase(state)) begin
            breakerUsed <= 1'b1;
         end
         if (toStop) begin
            pulseArmed <= 1'b0;
         end else if (tStart[`TMR_PULSE]) begin
            pulseArmed <= 1'b1;
         end
         engineElectronicsEnable <= enableNow;
         fuelOut     <= fuelNow;
         stopOut     <= stopNow;
         oilProtMask <= tBusy[`TMR_MASK];
         if ((state == ST_STOPPING) && tFin[`TMR_MAX] && engineTurning) begin
            engineNotStoppedAlarm <= 1'b1;
         end else if (alarmClr) begin
            engineNotStoppedAlarm <= 1'b0;
         end
      end
   end

   // Engine signalling outputs and flags
   always @(posedge mclk) begin
      if (!rstn) begin
         engineRunningOutput <= 1'b0;
         readyToSupplyOutput <= 1'b0;
         statusFlags         <= 9'h000;
      end else if (ce) begin
         engineRunningOutput <= engineTurning;
         readyToSupplyOutput <= engineTurning & tFin[`TMR_PRED];
         statusFlags <= {state == ST_STOPPING,
                         state == ST_COOLING,
                         engineTurning & tFin[`TMR_PRED],
                         tBusy[`TMR_PRED],
                         state == ST_LOWSPEED,
                         state == ST_STARTING,
                         ~engineTurning,
                         engineTurning & tFin[`TMR_MASK],
                         engineTurning};
      end
   end

   // Event log: state changes first, pending requests after
   always @(posedge mclk) begin
      if (!rstn) begin
         reqPend    <= 14'h0000;
         eventValid <= 1'b0;
         eventCode  <= 16'h0000;
         lastEvt    <= 16'h0000;
      end else if (ce) begin
         eventValid <= 1'b0;
         if (change && evtEn[`EVTEN_STATE]) begin
            eventValid <= 1'b1;
            eventCode  <= `EVT_STATE_BASE + {13'h0000, next_state};
            lastEvt    <= `EVT_STATE_BASE + {13'h0000, next_state};
            reqPend    <= reqPend | reqChange;
         end else if ((|reqPend) && evtEn[`EVTEN_REQ]) begin
            eventValid <= 1'b1;
            eventCode  <= `EVT_REQ_BASE + {12'h000, firstSet(reqPend)};
            lastEvt    <= `EVT_REQ_BASE + {12'h000, firstSet(reqPend)};
            reqPend    <= (reqPend & ~(14'h0001 << firstSet(reqPend))) |
                          reqChange;
         end else if (evtEn[`EVTEN_REQ]) begin
            reqPend <= reqPend | reqChange;
         end else begin
            reqPend <= 14'h0000;
         end
      end
   end

   // Read data for the addressed register
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      if (address[1:0] == 2'h0 && address[7:2] < `TMR_WORDS) begin
         rdMux[TW-1:0] = span[address[4:2]];
      end else begin
         case (address)
            `REG_SRC_SEL:  rdMux[1:0] = srcSel;
            `REG_COOL_THR: rdMux[15:0] = coolThr;
            `REG_EVT_EN:   rdMux[15:0] = evtEn;
            `REG_STATUS: begin
               rdMux[8:0] = statusFlags;
               rdMux[`STAT_ALARM] = engineNotStoppedAlarm;
               rdMux[`STAT_STATE_LSB+2:`STAT_STATE_LSB] = state;
            end
            `REG_LAST_EVT: rdMux[15:0] = lastEvt;
            default:       rdMux = 32'h00000000;
         endcase
      end
   end

   // Bus handshake and configuration writes
   integer k;
   always @(posedge mclk) begin
      if (!rstn) begin
         busAck   <= 1'b0;
         readdata <= 32'h00000000;
         srcSel   <= `RST_SRC;
         coolThr  <= `RST_THR;
         evtEn    <= `RST_EVT_EN;
         for (k = 0; k < `TMR_COUNT; k = k + 1) begin
            span[k] <= `RST_SPAN;
         end
      end else if (ce) begin
         busAck <= (read | write) & ~busAck;
         if (read && !busAck) begin
            readdata <= rdMux;
         end
         if (wrEn) begin
            if (address[1:0] == 2'h0 && address[7:2] < `TMR_WORDS) begin
               span[address[4:2]] <= writedata[TW-1:0];
            end
            if (address == `REG_SRC_SEL) begin
               srcSel <= writedata[1:0];
            end
            if (address == `REG_COOL_THR) begin
               coolThr <= writedata[15:0];
            end
            if (address == `REG_EVT_EN) begin
               evtEn <= writedata[15:0];
            end
         end
      end
   end

endmodule

`default_nettype wire

/* engine_stop_sequencer_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module engine_stop_sequencer_asserts (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rstn,
   // Stimulus seen at the block
   input wire logic        emgStopReq,
   input wire logic        manStopReq,
   input wire logic        engineTurning,
   // Block outputs
   input wire logic        engineElectronicsEnable,
   input wire logic        fuelOut,
   input wire logic        stopOut,
   input wire logic        oilProtMask,
   input wire logic        engineRunningOutput,
   input wire logic        readyToSupplyOutput,
   input wire logic [8:0]  statusFlags,
   input wire logic        engineNotStoppedAlarm,
   input wire logic        eventValid,
   input wire logic [15:0] eventCode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // Stopping phase shows within three edges of its cause
   sequence s_stop_soon;
      ##[1:3] statusFlags[8];
   endsequence
   // Engine held in one motion state for three edges
   sequence s_turning;
      engineTurning[*3];
   endsequence
   sequence s_resting;
      !engineTurning[*3];
   endsequence

   a_stop_fuel_apart: assert property (!(stopOut && fuelOut))
      else $error("stop and fuel outputs overlap");
   a_emg_direct: assert property (emgStopReq && statusFlags[0] |-> s_stop_soon)
      else $error("emergency stop did not reach stopping");
   a_man_abort: assert property (manStopReq && statusFlags[7] |-> s_stop_soon)
      else $error("manual stop did not abort cooling");
   a_enable_off: assert property (statusFlags[8] && $past(statusFlags[8]) |-> !engineElectronicsEnable)
      else $error("electronics enable high while stopping");
   a_run_out_on: assert property (s_turning |=> engineRunningOutput)
      else $error("running output low with engine turning");
   a_run_out_off: assert property (s_resting |=> !engineRunningOutput)
      else $error("running output high with engine at rest");
   a_ready_needs_run: assert property (readyToSupplyOutput |->
      statusFlags[0] && statusFlags[6] && !statusFlags[5])
      else $error("ready output without running");
   a_mask_elapsed: assert property (statusFlags[1] |-> !oilProtMask)
      else $error("oil mask held after masking elapsed");
   a_alarm_cause: assert property ($rose(engineNotStoppedAlarm) |-> $past(engineTurning) || $past(engineTurning, 2))
      else $error("alarm raised with engine at rest");
   a_stopped_flag: assert property (s_resting |-> statusFlags[2])
      else $error("stopped flag low with engine at rest");
   a_event_codes: assert property (eventValid |-> eventCode inside {[16'h0410:16'h0415], [16'h041a:16'h0427]})
      else $error("event code out of range");
endmodule

bind engine_stop_sequencer engine_stop_sequencer_asserts u_chk (
   .mclk, .rstn, .emgStopReq, .manStopReq, .engineTurning,
   .engineElectronicsEnable, .fuelOut, .stopOut, .oilProtMask,
   .engineRunningOutput, .readyToSupplyOutput, .statusFlags,
   .engineNotStoppedAlarm, .eventValid, .eventCode
);
`default_nettype wire

/* engine_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module engine_partner (
   // Clock
   input wire logic  mclk,
   // Actuators from the block
   input wire logic  fuelOut,
   input wire logic  stopOut,
   // Scenario controls
   input wire logic  stuck,
   input wire logic  closeCmd,
   input wire logic  openCmd,
   // Feedback
   output wire logic engineTurning,
   output wire logic breakerClosed
);
   logic [2:0] spin = 3'h0;
   logic       closed = 1'b0;
   // Engine spins on fuel, coasts four cycles after fuel is cut
   always @(posedge mclk) begin
      if (fuelOut && !stopOut)
         spin <= 3'h4;
      else if (spin != 3'h0)
         spin <= spin - 3'h1;
   end
   // Breaker closes on command, an open command wins
   always @(posedge mclk) begin
      closed <= openCmd ? 1'b0 : (closeCmd ? 1'b1 : closed);
   end
   assign engineTurning = stuck || (spin != 3'h0); // Seized engine never rests
   assign breakerClosed = closed;
endmodule
`default_nettype wire

/* engine_stop_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module engine_stop_sequencer_tb;
   // Driven by the bench
   logic        mclk, rstn, secTick, read, write, startReq, runReq;
   logic        stdStopReq, emgStopReq, manStopReq, autoMode, dischargeDone;
   logic        openCmd, closeCmd, stuck;
   logic [7:0]  address;
   logic [31:0] writedata, rd;
   logic [13:0] reqChange;
   logic [3:0]  srcVoltOk;
   logic [1:0]  tcnt;
   logic [15:0] lastEvt, coolTemp;
   logic        lowSpeed;
   int          bad_count, cmp_count;
   // Block outputs and partner feedback
   wire logic [31:0] readdata;
   wire logic [15:0] eventCode;
   wire logic [8:0]  statusFlags;
   wire logic        waitrequest, eEn, fuelOut, stopOut, oilProtMask, runOut;
   wire logic        readyOut, alarm, eventValid, engineTurning, brk;

   engine_stop_sequencer dut (
      .mclk, .rstn, .ce(1'b1), .secTick, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .startReq, .runReq,
      .stdStopReq, .emgStopReq, .manStopReq, .reqChange,
      .engineStarted(engineTurning), .engineTurning, .lowSpeedReq(lowSpeed),
      .autoMode, .generatorBreakerClosed(brk),
      .generatorBreakerOpenCmd(openCmd), .dischargeDone,
      .coolantTemp(coolTemp), .srcVoltOk, .engineElectronicsEnable(eEn),
      .fuelOut, .stopOut, .oilProtMask, .engineRunningOutput(runOut),
      .readyToSupplyOutput(readyOut), .statusFlags,
      .engineNotStoppedAlarm(alarm), .eventValid, .eventCode
   );
   engine_partner eng (
      .mclk, .fuelOut, .stopOut, .stuck, .closeCmd, .openCmd,
      .engineTurning, .breakerClosed(brk)
   );

   // Clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Seconds tick every fourth cycle; last event seen
   always @(posedge mclk) begin
      tcnt <= tcnt + 2'h1;
      secTick <= (tcnt == 2'h3);
      if (eventValid === 1'b1)
         lastEvt <= eventCode;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One bus access held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic waitf(input int b, input logic v, input int lim, output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (statusFlags[b] !== v && n < lim);
      @(posedge mclk);
      if (n >= lim)
         chk(32'h0, 32'h1, "flag wait");
   endtask

   task automatic run_up(input logic auto);
      int n;
      autoMode <= auto;
      startReq <= 1'b1;
      @(posedge mclk);
      startReq <= 1'b0;
      waitf(0, 1'b1, 100, n);
      @(negedge mclk);
      chk(oilProtMask, 1'b1, "oil mask");
      chk(runOut, 1'b1, "running output");
      waitf(1, 1'b1, 100, n);
      @(negedge mclk);
      chk(oilProtMask, 1'b0, "oil mask held");
      waitf(6, 1'b1, 100, n);
      @(negedge mclk);
      chk(readyOut, 1'b1, "ready output");
      @(posedge mclk);
   endtask

   // Follows one stopping cycle from its first cycle to its end
   task automatic stop_seq(input logic early);
      int n, m;
      n = 0;
      m = 0;
      @(negedge mclk);
      chk(eEn, 1'b0, "enable held");
      chk(fuelOut, 1'b1, "fuel cut early");
      while (stopOut !== 1'b1 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      chk(fuelOut, 1'b0, "fuel with stop");
      chk(n >= 3, 1'b1, "fuel delay short");
      while (stopOut === 1'b1 && m < 60) begin
         @(negedge mclk);
         m++;
      end
      if (!early)
         chk(m >= 4 && m <= 12, 1'b1, "stop pulse");
      n += m;
      while (statusFlags[8] === 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk(n >= 24, !early, "stopping length");
      repeat (2) @(posedge mclk);
   endtask

   task automatic t_regs;
      logic [31:0] sp [6] = '{32'h3, 32'h2, 32'h2, 32'h8, 32'h2, 32'h2};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0, "span reset");
         bus(1'b1, 8'(i * 4), sp[i]);
         bus(1'b0, 8'(i * 4), 32'h0);
         chk(rd, sp[i], "span readback");
      end
      bus(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0, "event enable reset");
      bus(1'b0, 8'h3c, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b0, 8'h28, 32'h0);
      chk(rd[2], 1'b1, "stopped flag");
      bus(1'b1, 8'h20, 32'h90);
   endtask

   task automatic t_emg;
      int n;
      run_up(1'b0);
      stuck <= 1'b1;
      emgStopReq <= 1'b1;
      @(posedge mclk);
      emgStopReq <= 1'b0;
      waitf(8, 1'b1, 6, n);
      stop_seq(1'b0);
      @(negedge mclk);
      chk(alarm, 1'b1, "alarm");
      chk(lastEvt, 16'h0410, "idle event");
      @(posedge mclk);
      stuck <= 1'b0;
      reqChange <= 14'h0008;
      @(posedge mclk);
      reqChange <= 14'h0000;
      repeat (8) @(posedge mclk);
      bus(1'b1, 8'h24, 32'h8);
      bus(1'b0, 8'h28, 32'h0);
      chk(rd[9], 1'b0, "alarm clear");
      bus(1'b0, 8'h2c, 32'h0);
      chk(rd, 32'h041d, "request event");
   endtask

   task automatic cool_stop(input logic [1:0] s, input logic man);
      int n;
      bus(1'b1, 8'h18, {30'h0, s});
      run_up(1'b1);
      srcVoltOk <= ~(4'h1 << s);
      closeCmd <= 1'b1;
      dischargeDone <= 1'b0;
      repeat (4) @(posedge mclk);
      closeCmd <= 1'b0;
      stdStopReq <= 1'b1;
      @(posedge mclk);
      stdStopReq <= 1'b0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      chk(statusFlags[8:7], 2'h0, "stop with breaker closed");
      chk(statusFlags[0], 1'b1, "running without volts");
      @(posedge mclk);
      srcVoltOk <= 4'hf;
      openCmd <= 1'b1;
      dischargeDone <= 1'b1;
      waitf(7, 1'b1, 30, n);
      srcVoltOk <= ~(4'h1 << s);
      manStopReq <= man;
      @(posedge mclk);
      manStopReq <= 1'b0;
      waitf(8, 1'b1, 60, n);
      chk(n >= 8, !man && s == 2'h0, "cooling length");
      stop_seq(1'b0);
      openCmd <= 1'b0;
      srcVoltOk <= 4'hf;
   endtask

   task automatic t_restart;
      int n;
      run_up(1'b1);
      stdStopReq <= 1'b1;
      @(posedge mclk);
      stdStopReq <= 1'b0;
      waitf(8, 1'b1, 8, n);
      chk(n <= 4, 1'b1, "cooling not skipped");
      runReq <= 1'b1;
      stop_seq(1'b1);
   endtask

   // Low speed phase, hot coolant forces cooling, cold coolant ends it
   task automatic t_coolant;
      int n;
      runReq <= 1'b0;
      bus(1'b1, 8'h1c, 32'h50);
      coolTemp <= 16'h0060;
      run_up(1'b0);
      lowSpeed <= 1'b1;
      waitf(4, 1'b1, 8, n);
      chk(n <= 4, 1'b1, "low speed flag late");
      lowSpeed <= 1'b0;
      stdStopReq <= 1'b1;
      @(posedge mclk);
      stdStopReq <= 1'b0;
      waitf(7, 1'b1, 8, n);
      chk(n <= 4, 1'b1, "hot coolant not cooled");
      coolTemp <= 16'h0040;
      waitf(8, 1'b1, 8, n);
      chk(n <= 4, 1'b1, "cooling outlived cold coolant");
      stop_seq(1'b0);
   endtask

   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (6000) @(posedge mclk);
      bad_count++;
      tally_and_finish;
   end

   // Main sequence
   initial begin
      {rstn, secTick, read, write, startReq, runReq, stdStopReq} = '0;
      {emgStopReq, manStopReq, autoMode, dischargeDone, openCmd} = '0;
      {closeCmd, stuck, tcnt, address, writedata, reqChange} = '0;
      {coolTemp, lowSpeed} = '0;
      srcVoltOk = 4'hf;
      lastEvt = 16'h0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_regs;
      t_emg;
      for (int s = 0; s < 4; s++)
         cool_stop(2'(s), 1'b0);
      cool_stop(2'h0, 1'b1);
      t_restart;
      t_coolant;
      tally_and_finish;
   end
endmodule
`default_nettype wire
